// *** hdl/swp_pkg.sv ***
// Package: constants, register map and types of the sleep/wake controller
package swp_pkg;

    // Clock and derived low-frequency tick
    localparam int CLK_HZ = 50_000_000; // Core clock rate
    localparam int LF_OSC_HZ = 31_000; // Low-frequency oscillator rate
    localparam int LF_DIV = CLK_HZ / LF_OSC_HZ; // Core cycles per slow tick

    // Oscillator start-up delay, one oscillator period per core cycle
    localparam int OST_TOSC = 1024; // Start-up delay in oscillator periods
    localparam int OST_CYCLES = OST_TOSC * 1; // Same in core cycles
    localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1); // Final count

    // Byte addresses of the registers
    localparam logic [7:0] ADR_INT_CTRL = 8'h00; // interrupt_control
    localparam logic [7:0] ADR_CORE_STATUS = 8'h04; // core_status
    localparam logic [7:0] ADR_WDT_CTRL = 8'h08; // watchdog_control
    localparam logic [7:0] ADR_SLEEP_CFG = 8'h0c; // Configuration word

    // interrupt_control fields
    localparam int INTC_GIE = 7; // global_int_enable

    // core_status fields
    localparam int STAT_TO = 4; // time_out_flag
    localparam int STAT_PD = 3; // power_down_flag

    // watchdog_control fields
    localparam int WDTC_SWEN = 0; // soft_watchdog_enable
    localparam int WDTC_PS_LSB = 1; // watchdog_period_select low bit
    localparam logic [4:0] WDT_PS_MAX = 5'h12; // Largest valid select
    localparam logic [4:0] WDT_PS_LOG2_MIN = 5'h05; // 1:32 prescale

    // Configuration word fields
    localparam int CFG_WDTE_LSB = 0; // Watchdog mode, two bits
    localparam int CFG_EXTRST_EN = 2; // external_reset_pin enable
    localparam int CFG_BOR_EN = 3; // brownout_reset enable
    localparam int CFG_CRYSTAL = 4; // Crystal oscillator mode
    localparam int CFG_CONV_RC = 5; // Converter on its own RC clock
    localparam int CFG_VCAP_LSB = 6; // regulator_cap_pin_select

    // Watchdog modes
    localparam logic [1:0] WDTE_OFF = 2'h0; // Always off
    localparam logic [1:0] WDTE_SOFT = 2'h1; // Software controlled
    localparam logic [1:0] WDTE_NOSLEEP = 2'h2; // On except in sleep
    localparam logic [1:0] WDTE_ON = 2'h3; // Always on

    // Reset values
    localparam logic [7:0] INT_CTRL_RST = 8'h00; // All enables off
    localparam logic [7:0] WDT_CTRL_RST = 8'h16; // 1:65536, soft off
    localparam logic [7:0] SLEEP_CFG_RST = 8'hc0; // No cap pin, wdt off
    localparam logic [2:0] ZDC_RST = 3'h0; // Arithmetic flags

    // Controller states
    typedef enum logic [2:0] {
        ST_PWRUP,
        ST_RESET,
        ST_RUN,
        ST_SLEEP,
        ST_OST
    } swp_state_e;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } swp_wb_req_s;

endpackage

// *** hdl/swp_sleep_wake.sv ***
// Module: sleep entry, wake-up, watchdog and regulator reset control
`timescale 1ns/1ps

module swp_sleep_wake #(
    parameter int LF_DIV = swp_pkg::LF_DIV, // Core cycles per slow tick
    parameter int IRQ_W = 4 // Number of interrupt sources
) (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire swp_pkg::swp_wb_req_s wb_req_i, // Wishbone request
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic sleep_instr_i, // CPU executes sleep, one cycle
    input wire logic wdt_clear_instr_i, // CPU executes watchdog clear
    input wire logic [IRQ_W-1:0] irq_flag_i, // Interrupt flags
    input wire logic ext_reset_pin_n_i, // external_reset_pin, low active
    input wire logic brownout_i, // brownout_reset detector
    input wire logic por_i, // Power-on reset detector
    input wire logic cap_charged_i, // Regulator capacitor charged
    output logic cpu_clk_en_o, // CPU clock gate open
    output logic device_reset_o, // Device held in reset
    output logic charge_src_en_o, // Capacitor current source on
    output logic prefetch_o, // Prefetch PC + 1, one cycle
    output logic resume_o, // Execution resumes, one cycle
    output logic vector_irq_o, // Vector after prefetched instr
    output logic io_hold_o, // Pins keep their drive state
    output logic low_freq_osc_run_o, // low_freq_internal_osc enable
    output logic timer_osc_run_o, // Timer oscillator enable
    output logic cap_sense_osc_run_o, // Sensing oscillator enable
    output logic converter_clk_run_o, // Converter clock enable
    output logic [2:0] vcap_pin_o // One-hot: bit 6, bit 5, bit 0
);

    // Refuse parameter values the logic cannot serve
    if (LF_DIV < 2 || LF_DIV > 65535) begin : g_chk_div
        $error("LF_DIV out of range");
    end
    if (IRQ_W < 1 || IRQ_W > 7) begin : g_chk_irq
        $error("IRQ_W out of range");
    end

    // Watchdog terminal count for a period select
    function automatic logic [23:0] wdt_limit(input logic [4:0] sel);
        logic [23:0] lim;
        if (sel > swp_pkg::WDT_PS_MAX) begin
            lim = 24'h1 << swp_pkg::WDT_PS_LOG2_MIN;
        end else begin
            lim = 24'h1 << (sel + swp_pkg::WDT_PS_LOG2_MIN);
        end
        return lim;
    endfunction

    swp_pkg::swp_state_e state_q; // Controller state
    swp_pkg::swp_state_e state_d; // Next state
    logic [3:0] pin_meta_q; // First synchroniser stage
    logic [3:0] pin_sync_q; // Second synchroniser stage
    logic [15:0] lf_cnt_q; // Slow tick divider
    logic lf_tick_q; // Slow tick, one cycle
    logic [23:0] wdt_cnt_q; // Watchdog counter
    logic [10:0] ost_cnt_q; // Start-up delay counter
    logic wake_irq_q; // Last wake came from an interrupt
    logic to_q; // time_out_flag
    logic pd_q; // power_down_flag
    logic [2:0] zdc_q; // Arithmetic flags of core_status
    logic [7:0] int_ctrl_q; // interrupt_control
    logic [7:0] wdt_ctrl_q; // watchdog_control
    logic [7:0] cfg_q; // Configuration word
    logic ext_rst_n_s; // Synchronised reset pin
    logic bor_s; // Synchronised brownout
    logic por_s; // Synchronised power-on reset
    logic cap_s; // Synchronised charge done
    logic rst_src; // Any full-reset source active
    logic pending; // Enabled interrupt flagged
    logic wdt_active; // Watchdog counting
    logic wdt_to; // Watchdog time-out, one cycle
    logic enter_sleep; // Sleep entry this cycle
    logic nop_sleep; // Sleep instruction as no-op
    logic wake; // Wake from sleep this cycle
    logic wake_irq; // Wake cause is an interrupt
    logic resume; // Execution resumes next cycle
    logic bus_req; // New bus request
    logic [1:0] wdte; // Watchdog mode

    assign ext_rst_n_s = pin_sync_q[0];
    assign bor_s = pin_sync_q[1];
    assign por_s = pin_sync_q[2];
    assign cap_s = pin_sync_q[3];
    assign wdte = cfg_q[swp_pkg::CFG_WDTE_LSB +: 2];
    assign bus_req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;

    // Two-stage synchroniser for the pin inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_q <= 4'h1;
            pin_sync_q <= 4'h1;
        end else begin
            pin_meta_q <= {cap_charged_i, por_i, brownout_i, ext_reset_pin_n_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Full-reset sources; power-on always, brownout and pin each behind its enable
    assign rst_src = por_s
        || (cfg_q[swp_pkg::CFG_BOR_EN] && bor_s)
        || (cfg_q[swp_pkg::CFG_EXTRST_EN] && !ext_rst_n_s);

    // Own enable bit only, global enable ignored
    assign pending = |(irq_flag_i & int_ctrl_q[IRQ_W-1:0]);

    // Watchdog mode decode; sleep may keep it counting
    always_comb begin
        case (wdte)
            swp_pkg::WDTE_ON: wdt_active = 1'b1;
            swp_pkg::WDTE_NOSLEEP: wdt_active = (state_q != swp_pkg::ST_SLEEP);
            swp_pkg::WDTE_SOFT: wdt_active = wdt_ctrl_q[swp_pkg::WDTC_SWEN];
            default: wdt_active = 1'b0;
        endcase
    end

    // Time-out when the counter reaches its selected period
    assign wdt_to = wdt_active && lf_tick_q && (wdt_cnt_q ==
        wdt_limit(wdt_ctrl_q[swp_pkg::WDTC_PS_LSB +: 5]) - 24'h1);

    // Slow time base, free running like the oscillator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lf_cnt_q <= 16'h0;
            lf_tick_q <= 1'b0;
        end else if (lf_cnt_q == 16'(LF_DIV - 1)) begin
            lf_cnt_q <= 16'h0;
            lf_tick_q <= 1'b1;
        end else begin
            lf_cnt_q <= lf_cnt_q + 16'h1;
            lf_tick_q <= 1'b0;
        end
    end

    // Next state and the events of this cycle
    always_comb begin
        state_d = state_q;
        enter_sleep = 1'b0;
        nop_sleep = 1'b0;
        wake = 1'b0;
        wake_irq = 1'b0;
        if (rst_src) begin
            // Power-on goes back through capacitor charging
            state_d = por_s ? swp_pkg::ST_PWRUP : swp_pkg::ST_RESET;
        end else begin
            case (state_q)
                // Held until the regulator capacitor is charged
                swp_pkg::ST_PWRUP: begin
                    if (cap_s) begin
                        state_d = swp_pkg::ST_RUN;
                    end
                end
                // One cycle of reset once the sources are gone
                swp_pkg::ST_RESET: state_d = swp_pkg::ST_RUN;
                swp_pkg::ST_RUN: begin
                    if (wdt_to) begin
                        // Awake time-out resets the device
                        state_d = swp_pkg::ST_RESET;
                    end else if (sleep_instr_i) begin
                        if (pending) begin
                            // Already flagged: no-op
                            nop_sleep = 1'b1;
                        end else begin
                            // Only path into sleep
                            enter_sleep = 1'b1;
                            state_d = swp_pkg::ST_SLEEP;
                        end
                    end
                end
                swp_pkg::ST_SLEEP: begin
                    // Stay asleep until a wake event
                    if (wdt_to || pending) begin
                        // Late flag wakes at once
                        wake = 1'b1;
                        wake_irq = pending;
                        state_d = cfg_q[swp_pkg::CFG_CRYSTAL] ?
                            swp_pkg::ST_OST : swp_pkg::ST_RUN;
                    end
                end
                swp_pkg::ST_OST: begin
                    // Crystal start-up delay
                    if (ost_cnt_q == swp_pkg::OST_LAST) begin
                        state_d = swp_pkg::ST_RUN;
                    end
                end
                default: state_d = swp_pkg::ST_PWRUP;
            endcase
        end
    end

    assign resume = (state_d == swp_pkg::ST_RUN)
        && ((state_q == swp_pkg::ST_SLEEP) || (state_q == swp_pkg::ST_OST));

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= swp_pkg::ST_PWRUP;
        end else begin
            state_q <= state_d;
        end
    end

    // Start-up delay counter, runs only in its state
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != swp_pkg::ST_OST) begin
            ost_cnt_q <= 11'h0;
        end else begin
            ost_cnt_q <= ost_cnt_q + 11'h1;
        end
    end

    // Watchdog counter and its clearing conditions
    always_ff @(posedge clk_i) begin
        if (rst_i || rst_src || !wdt_active
            || state_q == swp_pkg::ST_PWRUP
            || state_q == swp_pkg::ST_RESET) begin
            wdt_cnt_q <= 24'h0;
        end else if (enter_sleep) begin
            wdt_cnt_q <= 24'h0;
        end else if (wake || state_q == swp_pkg::ST_OST) begin
            wdt_cnt_q <= 24'h0;
        end else if (state_q == swp_pkg::ST_RUN && wdt_clear_instr_i) begin
            wdt_cnt_q <= 24'h0;
        end else if (lf_tick_q) begin
            wdt_cnt_q <= wdt_to ? 24'h0 : wdt_cnt_q + 24'h1;
        end
    end

    // Status flags; a no-op sleep leaves them alone
    always_ff @(posedge clk_i) begin
        if (rst_i || (rst_src && por_s)) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (state_q == swp_pkg::ST_RUN && wdt_to) begin
            to_q <= 1'b0;
        end else if (enter_sleep) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end else if (wake && wdt_to) begin
            to_q <= 1'b0;
            pd_q <= 1'b0;
        end
    end

    // Remember the wake cause for the vector decision
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_irq_q <= 1'b0;
        end else if (wake) begin
            wake_irq_q <= wake_irq;
        end
    end

    // CPU-facing outputs, all registered from the next state and this cycle's events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o <= 1'b0;
            device_reset_o <= 1'b1;
            charge_src_en_o <= 1'b1;
            prefetch_o <= 1'b0;
            resume_o <= 1'b0;
            vector_irq_o <= 1'b0;
            io_hold_o <= 1'b0;
        end else begin
            // Gate closed outside run
            cpu_clk_en_o <= (state_d == swp_pkg::ST_RUN);
            device_reset_o <= (state_d == swp_pkg::ST_PWRUP)
                || (state_d == swp_pkg::ST_RESET);
            charge_src_en_o <= (state_d == swp_pkg::ST_PWRUP);
            // Fetch PC + 1 as the sleep instruction runs
            prefetch_o <= enter_sleep || nop_sleep;
            resume_o <= resume;
            // Vector only for interrupt wake with global enable
            vector_irq_o <= resume && int_ctrl_q[swp_pkg::INTC_GIE]
                && (wake ? wake_irq : wake_irq_q);
            // Pins frozen until execution resumes
            io_hold_o <= (state_d == swp_pkg::ST_SLEEP)
                || (state_d == swp_pkg::ST_OST);
        end
    end

    // Clocks that sleep leaves alone; converter clock only when on its own RC clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_freq_osc_run_o <= 1'b1;
            timer_osc_run_o <= 1'b1;
            cap_sense_osc_run_o <= 1'b1;
            converter_clk_run_o <= 1'b1;
        end else begin
            low_freq_osc_run_o <= 1'b1;
            timer_osc_run_o <= 1'b1;
            cap_sense_osc_run_o <= 1'b1;
            converter_clk_run_o <= (state_d != swp_pkg::ST_SLEEP)
                || cfg_q[swp_pkg::CFG_CONV_RC];
        end
    end

    // Regulator capacitor pin decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vcap_pin_o <= 3'h0;
        end else begin
            case (cfg_q[swp_pkg::CFG_VCAP_LSB +: 2])
                2'h0: vcap_pin_o <= 3'h1; // port_a_bit0
                2'h1: vcap_pin_o <= 3'h2; // port_a_bit5
                2'h2: vcap_pin_o <= 3'h4; // port_a_bit6
                default: vcap_pin_o <= 3'h0; // No pin
            endcase
        end
    end

    // Wishbone acknowledge, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Register writes through byte lane 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_ctrl_q <= swp_pkg::INT_CTRL_RST;
            wdt_ctrl_q <= swp_pkg::WDT_CTRL_RST;
            cfg_q <= swp_pkg::SLEEP_CFG_RST;
            zdc_q <= swp_pkg::ZDC_RST;
        end else if (bus_req && wb_req_i.we && wb_req_i.sel[0]) begin
            case (wb_req_i.adr)
                swp_pkg::ADR_INT_CTRL: int_ctrl_q <= wb_req_i.dat[7:0];
                swp_pkg::ADR_CORE_STATUS: zdc_q <= wb_req_i.dat[2:0];
                swp_pkg::ADR_WDT_CTRL: wdt_ctrl_q <= {2'h0, wb_req_i.dat[5:0]};
                swp_pkg::ADR_SLEEP_CFG: cfg_q <= wb_req_i.dat[7:0];
                default: ; // Unmapped write ignored
            endcase
        end
    end

    // Read data, captured with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (bus_req) begin
            case (wb_req_i.adr)
                swp_pkg::ADR_INT_CTRL: wb_dat_o <= {24'h0, int_ctrl_q};
                swp_pkg::ADR_CORE_STATUS:
                    wb_dat_o <= {27'h0, to_q, pd_q, zdc_q};
                swp_pkg::ADR_WDT_CTRL: wb_dat_o <= {24'h0, wdt_ctrl_q};
                swp_pkg::ADR_SLEEP_CFG: wb_dat_o <= {24'h0, cfg_q};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    // Sleep is only ever reached from a sleep instruction
    property p_sleep_by_instr;
        @(posedge clk_i) disable iff (rst_i)
        $rose(state_q == swp_pkg::ST_SLEEP) |-> $past(sleep_instr_i);
    endproperty
    a_sleep_by_instr: assert property (p_sleep_by_instr)
        else $error("sleep entered without sleep instruction");

    // Entry leaves power-down clear and time-out set
    property p_entry_flags;
        @(posedge clk_i) disable iff (rst_i)
        $rose(state_q == swp_pkg::ST_SLEEP) |-> !pd_q && to_q;
    endproperty
    a_entry_flags: assert property (p_entry_flags)
        else $error("flags wrong on sleep entry");

    // Pending interrupt turns sleep into a no-op
    property p_nop_sleep;
        @(posedge clk_i) disable iff (rst_i)
        state_q == swp_pkg::ST_RUN && sleep_instr_i && pending
            && !rst_src && !wdt_to
        |=> state_q == swp_pkg::ST_RUN && $stable(pd_q) && $stable(to_q)
            && prefetch_o;
    endproperty
    a_nop_sleep: assert property (p_nop_sleep)
        else $error("no-op sleep changed state or flags");

    // CPU clock gate closed while asleep
    property p_clk_gated;
        @(posedge clk_i) disable iff (rst_i)
        state_q != swp_pkg::ST_RUN |-> !cpu_clk_en_o;
    endproperty
    a_clk_gated: assert property (p_clk_gated)
        else $error("cpu clock running outside run");

    // Enabled interrupt in sleep wakes on the next edge, counter cleared
    property p_irq_wake;
        @(posedge clk_i) disable iff (rst_i)
        state_q == swp_pkg::ST_SLEEP && pending && !rst_src
        |=> state_q != swp_pkg::ST_SLEEP && wdt_cnt_q == 24'h0;
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("enabled interrupt did not wake");

    // Start-up delay runs its full count before resuming
    property p_ost_len;
        @(posedge clk_i) disable iff (rst_i)
        $past(state_q) == swp_pkg::ST_OST && state_q == swp_pkg::ST_RUN
        |-> $past(ost_cnt_q) == swp_pkg::OST_LAST && resume_o;
    endproperty
    a_ost_len: assert property (p_ost_len)
        else $error("start-up delay cut short");

    // Capacitor pin select mapping
    property p_vcap;
        @(posedge clk_i) disable iff (rst_i)
        cfg_q[swp_pkg::CFG_VCAP_LSB +: 2] == 2'h1 |=> vcap_pin_o == 3'h2
            || $changed(cfg_q);
    endproperty
    a_vcap: assert property (p_vcap)
        else $error("capacitor pin decode wrong");

    // Sleeping time-out wakes without reset and marks both flags
    property p_wdt_wake;
        @(posedge clk_i) disable iff (rst_i)
        state_q == swp_pkg::ST_SLEEP && wdt_to && !rst_src
        |=> !to_q && !pd_q && !device_reset_o
            && state_q != swp_pkg::ST_SLEEP;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake)
        else $error("sleeping time-out handled wrong");

    // Awake time-out resets the device and clears time-out flag
    property p_wdt_reset;
        @(posedge clk_i) disable iff (rst_i)
        state_q == swp_pkg::ST_RUN && wdt_to && !rst_src
        |=> device_reset_o && !to_q ##1 !device_reset_o || rst_src;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset)
        else $error("awake time-out reset wrong");

    // Held in reset with source on while the capacitor charges
    property p_charge_hold;
        @(posedge clk_i) disable iff (rst_i)
        state_q == swp_pkg::ST_PWRUP && !cap_s
        |=> state_q == swp_pkg::ST_PWRUP && device_reset_o
            && charge_src_en_o;
    endproperty
    a_charge_hold: assert property (p_charge_hold)
        else $error("reset released before capacitor charged");

endmodule

// *** testbench/swp_sleep_wake_tb.sv ***
// Self-checking bench of the sleep/wake controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module swp_sleep_wake_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, sleep_q = 1'b0; // Clock, reset, sleep
    logic clr_q = 1'b0; // Watchdog clear instruction
    logic cnv; // Converter clock run
    wire [2:0] osc; // Oscillator run flags
    logic [3:0] irq_q = 4'h0; // Interrupt flags
    swp_pkg::swp_wb_req_s req_q = '0; // Bus request
    logic [31:0] dat, exp_d; // Read data, expected
    logic ack, cpu_en, dev_rst, chg, pf, res, vec, hold, cap, por, bo, pn, exp_v;
    logic [2:0] vcap; // Capacitor pin
    logic [2:0] vexp [4] = '{3'h1, 3'h2, 3'h4, 3'h0}; // Pin per select
    int err_total = 0, n_checks = 0, seed = 25360;
    logic [31:0] rd_q[$]; // Expected reads
    logic vec_q[$]; // Expected vector flags
    initial forever #10 clk_i = ~clk_i;
    swp_src_model SRC (.clk_i(clk_i), .charge_src_en_i(chg),
        .cap_charged_o(cap), .por_o(por), .brownout_o(bo),
        .ext_reset_pin_n_o(pn));
    swp_sleep_wake #(.LF_DIV(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(req_q), .wb_dat_o(dat), .wb_ack_o(ack),
        .sleep_instr_i(sleep_q), .wdt_clear_instr_i(clr_q),
        .irq_flag_i(irq_q), .ext_reset_pin_n_i(pn), .brownout_i(bo),
        .por_i(por), .cap_charged_i(cap), .cpu_clk_en_o(cpu_en),
        .device_reset_o(dev_rst), .charge_src_en_o(chg), .prefetch_o(pf),
        .resume_o(res), .vector_irq_o(vec), .io_hold_o(hold),
        .low_freq_osc_run_o(osc[0]), .timer_osc_run_o(osc[1]),
        .cap_sense_osc_run_o(osc[2]), .converter_clk_run_o(cnv),
        .vcap_pin_o(vcap));
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One classic bus cycle, held until ack
    task automatic bus(input logic we, input logic [7:0] a, d);
        int i;
        @(posedge clk_i);
        req_q <= '{1'b1, 1'b1, we, a, 4'hf, {24'h0, d}};
        for (i = 0; i < 20 && !(i > 0 && ack); i++) @(posedge clk_i);
        req_q <= '0;
        if (i == 20) begin err_total++; complete_run(); end
    endtask
    // Sleep pulse, late flags added as it is taken
    task automatic nap(input logic [3:0] late, input logic noop);
        @(posedge clk_i);
        sleep_q <= 1'b1;
        @(posedge clk_i);
        sleep_q <= 1'b0; // Next slot left as a no-op
        irq_q <= irq_q | late;
        #1;
        `CHK("prefetch", 1'b1, pf)
        `CHK("osc run", 3'h7, osc)
        `CHK("converter", noop, cnv)
        `CHK("cpu clock", noop, cpu_en)
        `CHK("io hold", !noop, hold)
    endtask
    // Bounded wait for resume, then clear flags
    task automatic wake(input int lim);
        int i;
        for (i = 0; i < lim && res !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == lim) begin
            err_total++;
            complete_run();
        end
        `CHK("clock back", 1'b1, cpu_en)
        @(posedge clk_i);
        irq_q <= 4'h0;
    endtask
    // Monitor: reads and resume vectors against notes
    always @(posedge clk_i) begin
        if (ack && !req_q.we) begin
            exp_d = rd_q.pop_front();
            `CHK("read", exp_d, dat)
        end
        if (res) begin
            exp_v = vec_q.pop_front();
            `CHK("vector", exp_v, vec)
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 200 && cpu_en !== 1'b1; i++) @(posedge clk_i);
        if (cpu_en !== 1'b1) begin
            err_total++;
            complete_run();
        end
        `CHK("released", 1'b0, dev_rst)
        rd_q.push_back(32'h18);
        bus(1'b0, 8'h04, 8'h00);
        rd_q.push_back(32'h0);
        bus(1'b0, 8'h10, 8'h00);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 8'h0c, 8'(s << 6));
            repeat (2) @(posedge clk_i);
            #1;
            `CHK("cap pin", vexp[s], vcap)
        end
        $display("reset and pin test done");
        bus(1'b1, 8'h00, 8'h01);
        irq_q <= 4'h1;
        nap(4'h0, 1'b1);
        irq_q <= 4'h0;
        rd_q.push_back(32'h18);
        bus(1'b0, 8'h04, 8'h00);
        $display("pending sleep test done");
        vec_q.push_back(1'b0);
        nap(4'h0, 1'b0);
        rd_q.push_back(32'h10);
        bus(1'b0, 8'h04, 8'h00);
        irq_q <= 4'($random(seed)) & 4'he;
        repeat (5) @(posedge clk_i);
        `CHK("no wake", 1'b0, cpu_en)
        irq_q <= irq_q | 4'h1;
        wake(30);
        $display("sleep wake test done");
        bus(1'b1, 8'h00, 8'h81);
        vec_q.push_back(1'b1);
        nap(4'h1, 1'b0);
        wake(30);
        rd_q.push_back(32'h10);
        bus(1'b0, 8'h04, 8'h00);
        $display("late interrupt test done");
        // Shortest period, always on, crystal start-up on wake
        bus(1'b1, 8'h08, 8'h00);
        clr_q <= 1'b1;
        bus(1'b1, 8'h0c, 8'hd3);
        repeat (200) @(posedge clk_i);
        rd_q.push_back(32'h10);
        bus(1'b0, 8'h04, 8'h00);
        clr_q <= 1'b0;
        for (int i = 0; i < 300 && dev_rst !== 1'b1; i++) @(posedge clk_i);
        if (dev_rst !== 1'b1) begin
            err_total++;
            complete_run();
        end
        rd_q.push_back(32'h0);
        bus(1'b0, 8'h04, 8'h00);
        vec_q.push_back(1'b0);
        nap(4'h0, 1'b0);
        wake(2000);
        rd_q.push_back(32'h0);
        bus(1'b0, 8'h04, 8'h00);
        bus(1'b1, 8'h0c, 8'hc0);
        $display("watchdog test done");
        complete_run();
    end
endmodule

// *** testbench/swp_src_model.sv ***
// Reset sources and regulator capacitor facing the controller
`timescale 1ns/1ps
module swp_src_model (
    input wire logic clk_i, // Core clock
    input wire logic charge_src_en_i, // Current source on
    output logic cap_charged_o, // Capacitor charged
    output logic por_o, // Power-on detector
    output logic brownout_o, // Brownout detector
    output logic ext_reset_pin_n_o // Reset pin, low active
);
    logic [3:0] charge_q = 4'h0; // Charge level, saturating
    // Capacitor fills only while the source feeds it
    always_ff @(posedge clk_i) begin
        if (charge_src_en_i && charge_q != 4'hf) begin
            charge_q <= charge_q + 4'h1;
        end
    end
    assign cap_charged_o = charge_q[3];
    // Healthy supply, pin released
    assign por_o = 1'b0;
    assign brownout_o = 1'b0;
    assign ext_reset_pin_n_o = 1'b1;
endmodule
